/* core/bptp_pkg.sv */
// Shared constants for the backplane test and protection control block
package bptp_pkg;
   localparam int NCH = 8;
   localparam int NPAIR = 4;
   // Register byte offsets
   localparam logic [7:0] OFS_LOOP_CTRL = 8'h00;
   localparam logic [7:0] OFS_FRAME_INJ = 8'h04;
   localparam logic [7:0] OFS_INJ_CMD = 8'h08;
   localparam logic [7:0] OFS_B1_MASK = 8'h0C;
   localparam logic [7:0] OFS_SERIAL_SEL = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   // Loop control fields
   localparam int POS_NEAR_CDR = 0;
   localparam int POS_NEAR_LVDS = 1;
   localparam int POS_FAR = 2;
   localparam int POS_PROT_SEL = 4;
   // Frame injection fields
   localparam int POS_FRAME_CNT = 0;
   localparam int POS_A1_VAL = 8;
   localparam int POS_A2_VAL = 16;
   // Injection command fields
   localparam int POS_FRAME_EN = 0;
   localparam int POS_B1_CMD = 8;
   localparam int POS_OVH_PAR = 16;
   localparam int POS_OUT_PAR = 24;
   // Status fields
   localparam int POS_READY = 0;
   localparam int POS_FAR_AVAIL = 1;
   localparam int POS_FRAME_BUSY = 8;
   localparam int POS_B1_PEND = 16;
   // Reset values
   localparam logic [31:0] RST_LOOP_CTRL = 32'h0000_0000;
   localparam logic [31:0] RST_FRAME_INJ = 32'h0000_0000;
   localparam logic [7:0] RST_FRAME_EN = 8'h00;
   localparam logic [7:0] RST_B1_CMD = 8'h00;
   localparam logic [7:0] RST_B1_MASK = 8'h00;
   localparam logic [7:0] RST_SERIAL_SEL = 8'h00;
   // Core ready delay in system clock cycles
   localparam logic [2:0] READY_DELAY = 3'h6;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : bptp_pkg

/* core/bptp_ctrl.sv */
// Test injection, loopback, protection and core-ready control with AXI4-Lite registers
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module bptp_ctrl
   import bptp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_cpu_port_wr,
   input wire logic [3:0] ext_cpu_port_prot_sel,
   input wire logic tx_frame_start,
   input wire logic tx_slot_last_a1,
   input wire logic tx_slot_first_a2,
   input wire logic tx_slot_b1,
   input wire logic [NCH-1:0][7:0] tx_byte_in,
   output logic [NCH-1:0][7:0] tx_work_byte,
   output logic [NCH-1:0][7:0] tx_protect_byte,
   input wire logic ovh_parity_slot,
   input wire logic [NCH-1:0] ovh_serial_in,
   output logic [NCH-1:0] ovh_serial_out,
   input wire logic rx_byte_valid,
   input wire logic [NCH-1:0][7:0] rx_aligned_byte,
   input wire logic [NCH-1:0] rx_aligned_parity,
   input wire logic align_fifo_in_use,
   output logic [NCH-1:0][7:0] parallel_out_byte_bus,
   output logic [NCH-1:0] parallel_out_parity_line,
   input wire logic [NCH-1:0] link_status_in,
   output logic [NCH-1:0] main_link_status,
   output logic [NCH-1:0] protect_link_status,
   output logic [NCH-1:0] serial_select_protect,
   input wire logic pointer_mover_bypass,
   output logic near_loop_cdr,
   output logic near_loop_lvds,
   output logic far_loop_active,
   output logic serial_tx_enable,
   input wire logic fabric_system_frame_pulse,
   input wire logic fabric_line_frame_pulse,
   input wire logic fabric_ovh_ck_en,
   output logic system_frame_pulse,
   output logic line_frame_pulse,
   output logic tx_overhead_clock_gate,
   output logic protect_select_pair_one,
   output logic protect_select_pair_three,
   output logic protect_select_pair_four,
   output logic local_bus_force_high,
   output logic output_enable,
   input wire logic cfg_done_pin,
   input wire logic io_release_pin,
   input wire logic core_rst_n_pin,
   input wire logic partial_cfg_pin,
   output logic core_ready
);
   // Byte-lane merge of a write
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
            r[b*8 +: 8] = dat[b*8 +: 8];
      end
      return r;
   endfunction : wmerge

   // Pin synchronisers, three stages
   logic [3:0] sy1_q, sy2_q, sy3_q, pin_q;
   logic [3:0] pin_d;
   logic [2:0] rdy_cnt_q, rdy_cnt_d;
   logic ready_q, ready_d;
   logic cfg_ok;
   always_comb
   begin
      for (int k = 0; k < 4; k++)
         pin_d[k] = (sy2_q[k] == sy3_q[k]) ? sy3_q[k] : pin_q[k];
      cfg_ok = pin_q[0] & pin_q[1] & pin_q[2];
      rdy_cnt_d = rdy_cnt_q;
      ready_d = ready_q;
      if (ready_q && pin_q[3])
         ready_d = 1'b1;
      else if (!cfg_ok)
      begin
         ready_d = 1'b0;
         rdy_cnt_d = 3'h0;
      end
      else if (rdy_cnt_q == READY_DELAY)
         ready_d = 1'b1;
      else
         rdy_cnt_d = rdy_cnt_q + 3'h1;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sy1_q <= 4'h0;
         sy2_q <= 4'h0;
         sy3_q <= 4'h0;
         pin_q <= 4'h0;
         rdy_cnt_q <= 3'h0;
         ready_q <= 1'b0;
      end
      else
      begin
         sy1_q <= {partial_cfg_pin, core_rst_n_pin, io_release_pin, cfg_done_pin};
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
         pin_q <= pin_d;
         rdy_cnt_q <= rdy_cnt_d;
         ready_q <= ready_d;
      end
   end
   // Core logic is held in reset until ready
   logic core_rst;
   assign core_rst = !aresetn || !ready_q;

   // AXI4-Lite slave and control registers
   logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] loop_q, loop_d, finj_q, finj_d, cmd_w;
   logic [7:0] fen_q, fen_d, b1cmd_q, b1cmd_d, mask_q, mask_d, ssel_q, ssel_d;
   logic [7:0] ovh_req, par_req;
   logic do_wr;
   logic [NCH-1:0] fbusy, b1pend;
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready = !w_have_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   always_comb
   begin
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      loop_d = loop_q;
      finj_d = finj_q;
      fen_d = fen_q;
      b1cmd_d = b1cmd_q;
      mask_d = mask_q;
      ssel_d = ssel_q;
      ovh_req = 8'h00;
      par_req = 8'h00;
      cmd_w = wmerge({8'h00, 8'h00, b1cmd_q, fen_q}, wdata_q, wstrb_q);
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_have_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      do_wr = aw_have_q && w_have_q;
      // External processor write of protect selects
      if (ext_cpu_port_wr)
         loop_d[POS_PROT_SEL +: 4] = ext_cpu_port_prot_sel;
      if (do_wr)
      begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = RESP_OKAY;
         unique case (awaddr_q)
            OFS_LOOP_CTRL: loop_d = wmerge(loop_q, wdata_q, wstrb_q);
            OFS_FRAME_INJ: finj_d = wmerge(finj_q, wdata_q, wstrb_q);
            OFS_INJ_CMD:
            begin
               fen_d = cmd_w[POS_FRAME_EN +: 8];
               b1cmd_d = cmd_w[POS_B1_CMD +: 8];
               ovh_req = cmd_w[POS_OVH_PAR +: 8] & {8{wstrb_q[2]}};
               par_req = cmd_w[POS_OUT_PAR +: 8] & {8{wstrb_q[3]}};
            end
            OFS_B1_MASK: mask_d = 8'(wmerge({24'h0, mask_q}, wdata_q, wstrb_q));
            OFS_SERIAL_SEL: ssel_d = 8'(wmerge({24'h0, ssel_q}, wdata_q, wstrb_q));
            OFS_STATUS: bresp_d = RESP_OKAY;
            default: bresp_d = RESP_SLVERR;
         endcase
      end
      if (bvalid_q && s_axi_bready)
         bvalid_d = 1'b0;
      if (rvalid_q && s_axi_rready)
         rvalid_d = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         unique case (s_axi_araddr)
            OFS_LOOP_CTRL: rdata_d = loop_q;
            OFS_FRAME_INJ: rdata_d = finj_q;
            OFS_INJ_CMD: rdata_d = {16'h0, b1cmd_q, fen_q};
            OFS_B1_MASK: rdata_d = {24'h0, mask_q};
            OFS_SERIAL_SEL: rdata_d = {24'h0, ssel_q};
            OFS_STATUS: rdata_d = {8'h0, 8'(b1pend), 8'(fbusy), 6'h0,
                                   !pointer_mover_bypass, ready_q};
            default:
            begin
               rdata_d = 32'h0000_0000;
               rresp_d = RESP_SLVERR;
            end
         endcase
      end
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end
      else
      begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end
   // Control registers sit in the core reset
   always_ff @(posedge aclk)
   begin
      if (core_rst)
      begin
         loop_q <= RST_LOOP_CTRL;
         finj_q <= RST_FRAME_INJ;
         fen_q <= RST_FRAME_EN;
         b1cmd_q <= RST_B1_CMD;
         mask_q <= RST_B1_MASK;
         ssel_q <= RST_SERIAL_SEL;
      end
      else
      begin
         loop_q <= loop_d;
         finj_q <= finj_d;
         fen_q <= fen_d;
         b1cmd_q <= b1cmd_d;
         mask_q <= mask_d;
         ssel_q <= ssel_d;
      end
   end

   // Injection state per channel
   logic [NCH-1:0] fen_prev_q, b1_prev_q, fact_q, fact_d, b1p_q, b1p_d, b1a_q, b1a_d;
   logic [NCH-1:0] opend_q, opend_d, ppend_q, ppend_d;
   logic [NCH-1:0][3:0] rem_q, rem_d;
   logic [NCH-1:0][7:0] txo_d, txo_q, pob_d, pob_q;
   logic [NCH-1:0] ovo_d, ovo_q, pop_d, pop_q;
   logic [3:0] psel;
   assign psel = loop_q[POS_PROT_SEL +: 4] & {4{align_fifo_in_use}};
   always_comb
   begin
      for (int i = 0; i < NCH; i++)
      begin
         rem_d[i] = rem_q[i];
         fact_d[i] = fact_q[i];
         if (fen_q[i] && !fen_prev_q[i])
            rem_d[i] = finj_q[POS_FRAME_CNT +: 4];
         else if (tx_frame_start)
         begin
            fact_d[i] = (rem_q[i] != 4'h0);
            if (rem_q[i] != 4'h0)
               rem_d[i] = rem_q[i] - 4'h1;
         end
         b1p_d[i] = (b1cmd_q[i] && !b1_prev_q[i]) || (b1p_q[i] && !tx_frame_start);
         b1a_d[i] = tx_frame_start ? b1p_q[i] : b1a_q[i];
         txo_d[i] = tx_byte_in[i];
         if (fact_q[i] && tx_slot_last_a1)
            txo_d[i] = finj_q[POS_A1_VAL +: 8];
         if (fact_q[i] && tx_slot_first_a2)
            txo_d[i] = finj_q[POS_A2_VAL +: 8];
         if (b1a_q[i] && tx_slot_b1)
            txo_d[i] = tx_byte_in[i] ^ mask_q;
         // Parity requests wait for their slot; a new request wins over the clear
         opend_d[i] = ovh_req[i] || (opend_q[i] && !ovh_parity_slot);
         ovo_d[i] = ovh_serial_in[i] ^ (opend_q[i] && ovh_parity_slot);
         ppend_d[i] = par_req[i] || (ppend_q[i] && !rx_byte_valid);
         pob_d[i] = rx_aligned_byte[i];
         pop_d[i] = rx_aligned_parity[i];
         if ((i % 2 == 0) && psel[i/2])
         begin
            pob_d[i] = rx_aligned_byte[i+1];
            pop_d[i] = rx_aligned_parity[i+1];
         end
         pop_d[i] = pop_d[i] ^ (ppend_q[i] && rx_byte_valid);
         fbusy[i] = fact_q[i] || (rem_q[i] != 4'h0);
      end
      b1pend = b1p_q | b1a_q;
   end
   always_ff @(posedge aclk)
   begin
      if (core_rst)
      begin
         fen_prev_q <= '0;
         b1_prev_q <= '0;
         fact_q <= '0;
         b1p_q <= '0;
         b1a_q <= '0;
         opend_q <= '0;
         ppend_q <= '0;
         rem_q <= '0;
         txo_q <= '0;
         pob_q <= '0;
         ovo_q <= '0;
         pop_q <= '0;
      end
      else
      begin
         fen_prev_q <= fen_q;
         b1_prev_q <= b1cmd_q;
         fact_q <= fact_d;
         b1p_q <= b1p_d;
         b1a_q <= b1a_d;
         opend_q <= opend_d;
         ppend_q <= ppend_d;
         rem_q <= rem_d;
         txo_q <= txo_d;
         pob_q <= pob_d;
         ovo_q <= ovo_d;
         pop_q <= pop_d;
      end
   end

   // Data, loopback and protection outputs
   assign tx_work_byte = txo_q;
   assign tx_protect_byte = txo_q;
   assign ovh_serial_out = ovo_q;
   assign parallel_out_byte_bus = pob_q;
   assign parallel_out_parity_line = pop_q;
   assign serial_select_protect = ssel_q;
   assign main_link_status = link_status_in & ~ssel_q;
   assign protect_link_status = link_status_in & ssel_q;
   assign near_loop_cdr = loop_q[POS_NEAR_CDR];
   assign near_loop_lvds = loop_q[POS_NEAR_LVDS] && !loop_q[POS_NEAR_CDR];
   assign far_loop_active = loop_q[POS_FAR] && !pointer_mover_bypass;
   assign serial_tx_enable = ready_q;
   assign output_enable = ready_q;
   assign local_bus_force_high = !ready_q;
   assign system_frame_pulse = fabric_system_frame_pulse && ready_q;
   assign line_frame_pulse = fabric_line_frame_pulse && ready_q;
   assign tx_overhead_clock_gate = fabric_ovh_ck_en && ready_q;
   // Selects forced low at once when ready drops, before the registers clear
   assign protect_select_pair_one = loop_q[POS_PROT_SEL] && ready_q;
   assign protect_select_pair_three = loop_q[POS_PROT_SEL+2] && ready_q;
   assign protect_select_pair_four = loop_q[POS_PROT_SEL+3] && ready_q;
   assign core_ready = ready_q;
endmodule : bptp_ctrl
`default_nettype wire

/* testbench/bptp_fabric_model.sv */
// Fabric-side frame timing model driving slot pulses and frame pulse
`timescale 1ns/100ps
`default_nettype none
module bptp_fabric_model #(parameter int FRAME_LEN = 32)
(
   input wire logic aclk,
   input wire logic aresetn,
   output logic tx_frame_start,
   output logic tx_slot_last_a1,
   output logic tx_slot_first_a2,
   output logic tx_slot_b1,
   output logic ovh_parity_slot,
   output logic fabric_system_frame_pulse
);
   logic [7:0] pos_q;
   // Byte position inside the frame
   always_ff @(posedge aclk)
   begin
      if (!aresetn || pos_q == 8'(FRAME_LEN - 1))
         pos_q <= 8'h00;
      else
         pos_q <= pos_q + 8'h01;
   end
   // Slot pulses decoded from the position
   assign tx_frame_start = aresetn && pos_q == 8'h00;
   assign ovh_parity_slot = pos_q == 8'h01;
   assign tx_slot_last_a1 = pos_q == 8'h02;
   assign tx_slot_first_a2 = pos_q == 8'h03;
   assign tx_slot_b1 = pos_q == 8'h05;
   assign fabric_system_frame_pulse = tx_frame_start;
endmodule : bptp_fabric_model
`default_nettype wire

/* testbench/bptp_ctrl_asserts.sv */
// Port-level checker for the test and protection control block
`timescale 1ns/100ps
`default_nettype none
module bptp_ctrl_chk
   import bptp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [NCH-1:0][7:0] tx_work_byte,
   input wire logic [NCH-1:0][7:0] tx_protect_byte,
   input wire logic serial_tx_enable,
   input wire logic output_enable,
   input wire logic core_ready,
   input wire logic local_bus_force_high,
   input wire logic system_frame_pulse,
   input wire logic line_frame_pulse,
   input wire logic tx_overhead_clock_gate,
   input wire logic protect_select_pair_one,
   input wire logic protect_select_pair_three,
   input wire logic protect_select_pair_four,
   input wire logic fabric_system_frame_pulse,
   input wire logic pointer_mover_bypass,
   input wire logic far_loop_active,
   input wire logic near_loop_cdr,
   input wire logic near_loop_lvds,
   input wire logic [NCH-1:0] link_status_in,
   input wire logic [NCH-1:0] main_link_status,
   input wire logic [NCH-1:0] protect_link_status,
   input wire logic [NCH-1:0] serial_select_protect,
   input wire logic cfg_done_pin,
   input wire logic io_release_pin,
   input wire logic core_rst_n_pin,
   input wire logic partial_cfg_pin
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Output relations to their causes
   a_tx_broadcast: assert property (tx_work_byte == tx_protect_byte)
      else $error("work and protect bytes differ");
   a_enable_ready: assert property (serial_tx_enable == core_ready && output_enable == core_ready)
      else $error("output enables do not follow core ready");
   a_bus_forced: assert property (local_bus_force_high != core_ready)
      else $error("local bus force wrong");
   a_pulse_forced: assert property (!core_ready |-> !(system_frame_pulse || line_frame_pulse
      || tx_overhead_clock_gate || protect_select_pair_one || protect_select_pair_three
      || protect_select_pair_four))
      else $error("forced-low output high while not ready");
   a_system_frame_pulse_pass: assert property (core_ready |-> system_frame_pulse == fabric_system_frame_pulse)
      else $error("frame pulse not passed through");
   a_far_bypass: assert property (pointer_mover_bypass |-> !far_loop_active)
      else $error("far loop active while bypassed");
   a_near_depth: assert property (near_loop_cdr |-> !near_loop_lvds)
      else $error("both near loop depths active");
   a_main_status: assert property (main_link_status == (link_status_in & ~serial_select_protect))
      else $error("main status not gated by select");
   a_unsel_status: assert property ((protect_link_status & ~serial_select_protect) == '0)
      else $error("status on unselected protect buffer");
   a_ready_delay: assert property ($rose(core_ready)
      |-> $past(cfg_done_pin && io_release_pin && core_rst_n_pin, 6))
      else $error("core ready rose too early");
   a_ready_drop: assert property ((!cfg_done_pin && !io_release_pin && !partial_cfg_pin) [*8]
      |=> !core_ready)
      else $error("core ready stayed high in reconfiguration");
endmodule : bptp_ctrl_chk
bind bptp_ctrl bptp_ctrl_chk u_chk (.*);
`default_nettype wire

/* testbench/testbench.sv */
// Register-driven testbench for the test and protection control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import bptp_pkg::*;
   localparam int FL = 32;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic ext_cpu_port_wr = 1'b0;
   logic [3:0] ext_cpu_port_prot_sel = 4'h0;
   logic [NCH-1:0][7:0] tx_byte_in = {NCH{8'h5A}}, rx_aligned_byte = '0;
   logic [NCH-1:0][7:0] tx_work_byte, tx_protect_byte, parallel_out_byte_bus;
   logic [NCH-1:0] ovh_serial_in = '0, rx_aligned_parity = 8'h10, link_status_in = 8'hFF;
   logic [NCH-1:0] ovh_serial_out, parallel_out_parity_line, main_link_status;
   logic [NCH-1:0] protect_link_status, serial_select_protect;
   logic rx_byte_valid = 1'b1, align_fifo_in_use = 1'b1, pointer_mover_bypass = 1'b0;
   logic fabric_line_frame_pulse = 1'b1, fabric_ovh_ck_en = 1'b1, partial_cfg_pin = 1'b0;
   logic cfg_done_pin = 1'b1, io_release_pin = 1'b1, core_rst_n_pin = 1'b1;
   logic tx_frame_start, tx_slot_last_a1, tx_slot_first_a2, tx_slot_b1, ovh_parity_slot;
   logic fabric_system_frame_pulse, near_loop_cdr, near_loop_lvds, far_loop_active, serial_tx_enable;
   logic system_frame_pulse, line_frame_pulse, tx_overhead_clock_gate, core_ready;
   logic protect_select_pair_one, protect_select_pair_three, protect_select_pair_four;
   logic local_bus_force_high, output_enable;
   logic [4:0] sl_q = '0;
   logic rdy_q = 1'b0;
   logic [31:0] b1s [4] = '{32'h400, 32'h400, 32'h0, 32'h400};
   int cnt [8] = '{default: 0};
   int error_cnt = 0;
   int cmp_count = 0;
   bptp_ctrl dut (.*);
   bptp_fabric_model #(.FRAME_LEN(FL)) u_fab (.*);
   // Clock at 25 MHz
   initial
   begin
      forever #20 aclk = ~aclk;
   end
   task automatic end_of_test();
      if (error_cnt == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test
   task automatic check(input logic [31:0] got, input logic [31:0] ex);
      cmp_count++;
      if (got !== ex)
      begin
         error_cnt++;
         $display("ERROR at %0t got %h expected %h", $time, got, ex);
      end
   endtask : check
   // Write: address and data offered together, each released when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw || w)
      begin
         @(posedge aclk);
         aw = aw && (s_axi_awready !== 1'b1);
         w = w && (s_axi_wready !== 1'b1);
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      do
         @(posedge aclk);
      while (s_axi_bvalid !== 1'b1);
      check(32'(s_axi_bresp), 32'(er));
      repeat (2) @(posedge aclk);
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
         @(posedge aclk);
      while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do
         @(posedge aclk);
      while (s_axi_rvalid !== 1'b1);
      check(s_axi_rdata, ex);
      check(32'(s_axi_rresp), 32'(er));
   endtask : axi_rd
   task automatic wait_ready(input logic lvl);
      int n;
      n = 0;
      while (core_ready !== lvl && n < 50)
      begin
         @(posedge aclk);
         n++;
      end
      check(32'(n < 50), 32'h1);
   endtask : wait_ready
   // Counters of altered bytes and bits, one cycle after each slot (cnt[4] in any cycle)
   always @(posedge aclk)
   begin
      sl_q <= {rx_byte_valid, ovh_parity_slot, tx_slot_b1, tx_slot_first_a2, tx_slot_last_a1};
      rdy_q <= (core_ready === 1'b1);
      // Skip the first ready cycle, outputs still show their reset values
      if (core_ready === 1'b1 && rdy_q)
      begin
         cnt[0] += int'(sl_q[0] && tx_work_byte[0] === 8'h3C);
         cnt[1] += int'(sl_q[1] && tx_work_byte[0] === 8'hC3);
         cnt[2] += int'(sl_q[0] && tx_work_byte[1] === 8'h3C);
         cnt[3] += int'(sl_q[2] && tx_work_byte[2] === 8'hDB);
         cnt[4] += int'(ovh_serial_out[0] === 1'b1);
         cnt[5] += int'(sl_q[4] && parallel_out_parity_line[3] === 1'b1);
         cnt[6] += int'(sl_q[4] && parallel_out_parity_line[4] === 1'b0);
         cnt[7] += int'(sl_q[3] && ovh_serial_out[0] === 1'b1);
      end
   end
   // Watchdog
   initial
   begin
      #200000;
      error_cnt++;
      end_of_test();
   end
   // Main sequence
   initial
   begin
      repeat (8) @(posedge aclk);
      check(32'({local_bus_force_high, output_enable}), 32'h2);
      aresetn <= 1'b1;
      wait_ready(1'b1);
      axi_rd(OFS_LOOP_CTRL, RST_LOOP_CTRL, RESP_OKAY);
      axi_rd(OFS_FRAME_INJ, RST_FRAME_INJ, RESP_OKAY);
      axi_rd(OFS_INJ_CMD, 32'h0, RESP_OKAY);
      axi_rd(OFS_B1_MASK, 32'(RST_B1_MASK), RESP_OKAY);
      axi_rd(OFS_SERIAL_SEL, 32'(RST_SERIAL_SEL), RESP_OKAY);
      axi_rd(OFS_STATUS, 32'h3, RESP_OKAY);
      axi_rd(8'h20, 32'h0, RESP_SLVERR);
      axi_wr(8'h20, 32'h1, RESP_SLVERR);
      check(32'({main_link_status, protect_link_status}), 32'hFF00);
      axi_wr(OFS_FRAME_INJ, 32'h00C3_3C03, RESP_OKAY);
      axi_wr(OFS_INJ_CMD, 32'h1, RESP_OKAY);
      repeat (8 * FL) @(posedge aclk);
      check(32'(cnt[0]), 32'h3);
      check(32'(cnt[1]), 32'h3);
      check(32'(cnt[2]), 32'h0);
      axi_wr(OFS_B1_MASK, 32'h81, RESP_OKAY);
      for (int i = 0; i < 4; i++)
      begin
         axi_wr(OFS_INJ_CMD, b1s[i], RESP_OKAY);
         repeat (3 * FL) @(posedge aclk);
      end
      check(32'(cnt[3]), 32'h2);
      rx_byte_valid <= 1'b0;
      axi_wr(OFS_INJ_CMD, 32'h1801_0000, RESP_OKAY);
      repeat (2 * FL) @(posedge aclk);
      check(32'(cnt[5]), 32'h0);
      rx_byte_valid <= 1'b1;
      repeat (2 * FL) @(posedge aclk);
      check(32'(cnt[4]), 32'h1);
      check(32'(cnt[7]), 32'h1);
      check(32'(cnt[5] + 2 * cnt[6]), 32'h3);
      for (int i = 0; i < 3; i++)
      begin
         axi_wr(OFS_LOOP_CTRL, 32'(1 << i), RESP_OKAY);
         check(32'({near_loop_cdr, near_loop_lvds, far_loop_active}), 32'(4 >> i));
      end
      pointer_mover_bypass <= 1'b1;
      axi_rd(OFS_STATUS, 32'h1, RESP_OKAY);
      pointer_mover_bypass <= 1'b0;
      for (int i = 0; i < NCH; i++)
         rx_aligned_byte[i] <= 8'(8'h10 + i);
      axi_wr(OFS_LOOP_CTRL, 32'h10, RESP_OKAY);
      check(32'({parallel_out_byte_bus[0], parallel_out_byte_bus[2]}), 32'h1112);
      align_fifo_in_use <= 1'b0;
      repeat (3) @(posedge aclk);
      check(32'(parallel_out_byte_bus[0]), 32'h10);
      align_fifo_in_use <= 1'b1;
      ext_cpu_port_prot_sel <= 4'hC;
      ext_cpu_port_wr <= 1'b1;
      @(posedge aclk);
      ext_cpu_port_wr <= 1'b0;
      repeat (3) @(posedge aclk);
      check(32'({protect_select_pair_four, protect_select_pair_three,
         protect_select_pair_one, parallel_out_byte_bus[6]}), 32'h617);
      axi_rd(OFS_LOOP_CTRL, 32'hC0, RESP_OKAY);
      link_status_in <= 8'h5A;
      axi_wr(OFS_SERIAL_SEL, 32'h0F, RESP_OKAY);
      check(32'({main_link_status, protect_link_status}), 32'h500A);
      partial_cfg_pin <= 1'b1;
      cfg_done_pin <= 1'b0;
      io_release_pin <= 1'b0;
      repeat (20) @(posedge aclk);
      check(32'(core_ready), 32'h1);
      partial_cfg_pin <= 1'b0;
      core_rst_n_pin <= 1'b0;
      wait_ready(1'b0);
      @(posedge aclk);
      check(32'({line_frame_pulse, tx_overhead_clock_gate, protect_select_pair_four,
         local_bus_force_high}), 32'h1);
      cfg_done_pin <= 1'b1;
      io_release_pin <= 1'b1;
      core_rst_n_pin <= 1'b1;
      repeat (7) @(posedge aclk);
      check(32'(core_ready), 32'h0);
      wait_ready(1'b1);
      axi_rd(OFS_LOOP_CTRL, 32'h0, RESP_OKAY);
      check(32'({line_frame_pulse, tx_overhead_clock_gate}), 32'h3);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
